// ### hdl/itt_pkg.sv
// Constants and carrier types for the two-wire thermometer and thermostat
package itt_pkg;

  localparam logic [7:0] ITT_CMD_CFG  = 8'hAC;
  localparam logic [7:0] ITT_CMD_HIGH = 8'hA1;
  localparam logic [7:0] ITT_CMD_LOW  = 8'hA2;
  localparam logic [7:0] ITT_CMD_CONV = 8'hEE;

  // Arbitrary bus address value
  localparam logic [6:0] ITT_SLAVE_ADDR = 7'h48;

  localparam int         ITT_CFG_POL     = 1;
  localparam int         ITT_CFG_ONESHOT = 0;
  localparam logic [7:0] ITT_CFG_WMASK   = 8'h03;

  localparam logic [2:0] ITT_PH_ADDR = 3'h0;
  localparam logic [2:0] ITT_PH_CMD  = 3'h1;
  localparam logic [2:0] ITT_PH_D1   = 3'h2;
  localparam logic [2:0] ITT_PH_D2   = 3'h3;
  localparam logic [2:0] ITT_PH_DONE = 3'h4;

  localparam int unsigned ITT_CONV_TIME_MS = 1000;
  localparam int unsigned ITT_CLK_KHZ      = 250000;
  localparam int unsigned ITT_CONV_CYCLES  = ITT_CONV_TIME_MS * ITT_CLK_KHZ;
  localparam int          ITT_CONV_CW      = 28;

  // Half-degree units, two's complement
  localparam logic signed [8:0] ITT_TEMP_MIN = 9'sh192;
  localparam logic signed [8:0] ITT_TEMP_MAX = 9'sh0FA;

  localparam logic        ITT_LINE_IDLE = 1'h1;
  localparam logic        ITT_ALARM_RST = 1'h1;
  localparam logic [15:0] ITT_TEMP_RST  = 16'h0000;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [15:0] high;
    logic [15:0] low;
  } itt_nv_t;

  localparam itt_nv_t ITT_NV_RST = 40'h00_0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } itt_state_t;

endpackage

// ### hdl/itt_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module itt_sync
  import itt_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);

  logic q1;
  logic q2;
  logic q3;
  wire  agree = (q2 == q3);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q1   <= ITT_LINE_IDLE;
      q2   <= ITT_LINE_IDLE;
      q3   <= ITT_LINE_IDLE;
      lvl  <= ITT_LINE_IDLE;
      rise <= 1'h0;
      fall <= 1'h0;
    end else begin
      q1   <= pin;
      q2   <= q1;
      q3   <= q2;
      rise <= agree & q3 & ~lvl;
      fall <= agree & ~q3 & lvl;
      if (agree) begin
        lvl <= q3;
      end
    end
  end

endmodule

// ### hdl/itt_thermostat.sv
// Two-wire command slave, conversion timer and hysteresis thermostat
`timescale 1ns/1ps
module itt_thermostat
  import itt_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ITT_CONV_CYCLES,
  parameter logic [6:0]  SLAVE_ADDR  = ITT_SLAVE_ADDR
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [8:0]  temp_sense,
  input  wire itt_nv_t     nv_restore,
  output itt_nv_t          nv_image,
  output logic             nv_write,
  output logic [15:0]      temp_word,
  output logic             conv_busy,
  output logic             conv_done,
  output logic             thermal_alarm_output
);

  localparam logic [ITT_CONV_CW-1:0] CONV_END = (ITT_CONV_CW)'(CONV_CYCLES - 1);

  function automatic logic signed [8:0] lim9(input logic [15:0] lim);
    lim9 = $signed(lim[15:7]);
  endfunction

  function automatic logic signed [8:0] clamp9(input logic signed [8:0] t);
    if (t < ITT_TEMP_MIN) begin
      clamp9 = ITT_TEMP_MIN;
    end else if (t > ITT_TEMP_MAX) begin
      clamp9 = ITT_TEMP_MAX;
    end else begin
      clamp9 = t;
    end
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic                   scl_lvl;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   sda_lvl;
  logic                   sda_rise;
  logic                   sda_fall;
  itt_state_t             state;
  logic [2:0]             bit_cnt;
  logic [7:0]             shreg;
  logic                   byte_full;
  logic [2:0]             phase;
  logic                   rw;
  logic [7:0]             cmd;
  logic [15:0]            tx_sh;
  logic [7:0]             data_hi;
  logic                   nv_loaded;
  logic [ITT_CONV_CW-1:0] conv_cnt;
  logic                   alarm_flag;

  itt_sync u_scl_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (scl_i),
    .lvl     (scl_lvl),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  itt_sync u_sda_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (sda_i),
    .lvl     (sda_lvl),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Bus conditions and byte decode
  wire       start_det  = sda_fall & scl_lvl;
  wire       stop_det   = sda_rise & scl_lvl;
  wire       st_rx      = (state == ST_RX);
  wire       acc        = st_rx & scl_fall & byte_full;
  wire       addr_hit   = (phase == ITT_PH_ADDR) && (shreg[7:1] == SLAVE_ADDR);
  wire       is_limit   = (cmd == ITT_CMD_HIGH) || (cmd == ITT_CMD_LOW);
  wire       wr_cfg     = acc && (phase == ITT_PH_D1) && (cmd == ITT_CMD_CFG);
  wire       wr_hi1     = acc && (phase == ITT_PH_D1) && is_limit;
  wire       wr_high    = acc && (phase == ITT_PH_D2) && (cmd == ITT_CMD_HIGH);
  wire       wr_low     = acc && (phase == ITT_PH_D2) && (cmd == ITT_CMD_LOW);
  wire       conv_cmd   = acc && (phase == ITT_PH_CMD) && (shreg == ITT_CMD_CONV);
  wire [2:0] next_phase = (phase == ITT_PH_DONE) ? phase : phase + 3'h1;

  // Conversion decode
  wire                    result_evt = conv_busy && (conv_cnt == CONV_END);
  wire logic signed [8:0] res9       = clamp9($signed(temp_sense));
  wire logic signed [8:0] high9      = lim9(nv_image.high);
  wire logic signed [8:0] low9       = lim9(nv_image.low);
  wire                    above_high = result_evt && (res9 > high9);
  wire                    below_low  = result_evt && (res9 < low9);

  // Open-drain data line only ever pulls low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sda_o <= 1'h0;
    end else begin
      sda_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_full <= 1'h0;
      phase     <= ITT_PH_ADDR;
      rw        <= 1'h0;
      cmd       <= 8'h00;
      tx_sh     <= 16'h0000;
      sda_oe    <= 1'h0;
    end else if (start_det) begin
      state     <= ST_RX;
      bit_cnt   <= 3'h0;
      byte_full <= 1'h0;
      phase     <= ITT_PH_ADDR;
      sda_oe    <= 1'h0;
    end else if (stop_det) begin
      state  <= ST_IDLE;
      sda_oe <= 1'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sda_oe <= 1'h0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg     <= {shreg[6:0], sda_lvl};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_full <= (bit_cnt == 3'h7);
          end else if (acc) begin
            byte_full <= 1'h0;
            if (phase == ITT_PH_ADDR) begin
              rw <= shreg[0];
            end
            if (phase == ITT_PH_CMD) begin
              cmd <= shreg;
            end
            if ((phase == ITT_PH_ADDR) && !addr_hit) begin
              state <= ST_IDLE;
            end else begin
              state  <= ST_ACK;
              sda_oe <= 1'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            phase   <= next_phase;
            if (rw) begin
              state  <= ST_TX;
              sda_oe <= ~temp_word[15];
              tx_sh  <= {temp_word[14:0], 1'h0};
            end else begin
              state  <= ST_RX;
              sda_oe <= 1'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              state  <= ST_MACK;
              sda_oe <= 1'h0;
            end else begin
              sda_oe <= ~tx_sh[15];
              tx_sh  <= {tx_sh[14:0], 1'h0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            byte_full <= ~sda_lvl;
          end else if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (byte_full) begin
              state  <= ST_TX;
              sda_oe <= ~tx_sh[15];
              tx_sh  <= {tx_sh[14:0], 1'h0};
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'h0;
        end
      endcase
    end
  end

  // Settings image; restored once after reset, pushed out on every write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nv_loaded <= 1'h0;
      nv_image  <= ITT_NV_RST;
      nv_write  <= 1'h0;
      data_hi   <= 8'h00;
    end else begin
      nv_write <= wr_cfg | wr_high | wr_low;
      if (!nv_loaded) begin
        nv_loaded <= 1'h1;
        nv_image  <= nv_restore;
      end
      if (wr_cfg) begin
        nv_image.cfg <= shreg & ITT_CFG_WMASK;
      end
      if (wr_hi1) begin
        data_hi <= shreg;
      end
      if (wr_high) begin
        nv_image.high <= {data_hi, shreg};
      end
      if (wr_low) begin
        nv_image.low <= {data_hi, shreg};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_busy            <= 1'h0;
      conv_cnt             <= '0;
      conv_done            <= 1'h0;
      temp_word            <= ITT_TEMP_RST;
      alarm_flag           <= 1'h0;
      thermal_alarm_output <= ITT_ALARM_RST;
    end else begin
      conv_done            <= result_evt;
      thermal_alarm_output <= nv_image.cfg[ITT_CFG_POL] ? alarm_flag : ~alarm_flag;
      if (conv_cmd) begin
        conv_busy <= 1'h1;
        conv_cnt  <= '0;
      end else if (result_evt) begin
        temp_word <= {res9, 7'h00};
        conv_cnt  <= '0;
        conv_busy <= ~nv_image.cfg[ITT_CFG_ONESHOT];
      end else if (conv_busy) begin
        conv_cnt <= conv_cnt + 1'b1;
      end
      if (above_high) begin
        alarm_flag <= 1'h1;
      end else if (below_low) begin
        alarm_flag <= 1'h0;
      end
    end
  end

  property p_ack_addr;
    acc && addr_hit |=> sda_oe && (state == ST_ACK);
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

  property p_nack_addr;
    acc && (phase == ITT_PH_ADDR) && !addr_hit |=> !sda_oe && (state == ST_IDLE);
  endproperty
  a_nack_addr: assert property (p_nack_addr) else $error("foreign address acknowledged");

  property p_ack_release;
    (state == ST_ACK) && scl_fall && !rw && !start_det && !stop_det |=> !sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");

  property p_shift_in;
    st_rx && scl_rise && !start_det && !stop_det |=> shreg == {$past(shreg[6:0]), $past(sda_lvl)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit order wrong");

  property p_cfg_write;
    wr_cfg |=> nv_write && (nv_image.cfg == ($past(shreg) & ITT_CFG_WMASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

  property p_high_write;
    wr_high |=> nv_write && (nv_image.high == {$past(data_hi), $past(shreg)});
  endproperty
  a_high_write: assert property (p_high_write) else $error("high limit not stored");

  property p_low_write;
    wr_low |=> nv_write && (nv_image.low == {$past(data_hi), $past(shreg)});
  endproperty
  a_low_write: assert property (p_low_write) else $error("low limit not stored");

  property p_restart_keeps;
    start_det && nv_loaded |=> (state == ST_RX) && (phase == ITT_PH_ADDR) && $stable(nv_image);
  endproperty
  a_restart_keeps: assert property (p_restart_keeps) else $error("restart lost state");

  property p_conv_start;
    conv_cmd |=> conv_busy && (conv_cnt == '0);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion not started");

  property p_conv_end;
    result_evt && !conv_cmd |=> conv_done && (temp_word[15:7] == $past(res9))
      && (conv_busy == !$past(nv_image.cfg[ITT_CFG_ONESHOT]));
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("conversion result wrong");

  property p_range;
    conv_done |-> ($signed(temp_word[15:7]) >= ITT_TEMP_MIN)
      && ($signed(temp_word[15:7]) <= ITT_TEMP_MAX) && (temp_word[6:0] == 7'h00);
  endproperty
  a_range: assert property (p_range) else $error("result out of range");

  property p_alarm_set;
    above_high |=> alarm_flag
      ##1 (thermal_alarm_output == $past(nv_image.cfg[ITT_CFG_POL]));
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not raised");

  property p_alarm_hold;
    alarm_flag && !below_low |=> alarm_flag;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");

  property p_polarity;
    $stable(nv_image.cfg) |=> thermal_alarm_output
      == ($past(nv_image.cfg[ITT_CFG_POL]) ~^ $past(alarm_flag));
  endproperty
  a_polarity: assert property (p_polarity) else $error("alarm polarity wrong");

  c_cfg_write:  cover property (wr_cfg && (shreg == 8'h02));
  c_high_write: cover property (wr_high);
  c_conv_done:  cover property (conv_done);
  c_alarm:      cover property (above_high);
  c_read:       cover property ((state == ST_MACK) && scl_fall && byte_full);

endmodule

// ### testbench/itt_master_model.sv
// Behavioural two-wire bus master that drives the link of the thermometer
`timescale 1ns/1ps
module itt_master_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One 32 ns bit cell, 24 ns low and 8 ns high; the line is read just
  // before the falling clock edge. The long low phase lets the slave's
  // answer, which trails its synchronised clock fall, settle before the rise.
  task automatic bit_cell(input logic v, output logic s);
    step(2);
    sda_pull = ~v;
    step(4);
    scl = 1'b1;
    step(2);
    s   = sda;
    scl = 1'b0;
  endtask

  // Plain start from idle, or repeated start when the clock is low
  task automatic start();
    if (scl === 1'b0) begin
      step(6);
      sda_pull = 1'b0;
      step(6);
      scl = 1'b1;
    end
    step(6);
    sda_pull = 1'b1;
    step(6);
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cell(b[i], s);
    bit_cell(1'b1, ack_n);
  endtask

  // Last byte is answered with no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(1'b1, s);
      b[i] = s;
    end
    bit_cell(last, s);
  endtask

  task automatic stop();
    step(6);
    sda_pull = 1'b1;
    step(6);
    scl = 1'b1;
    step(6);
    sda_pull = 1'b0;
    step(6);
  endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the two-wire thermometer and thermostat
`timescale 1ns/1ps
module tb;
  import itt_pkg::*;
  localparam int unsigned CONV   = 50;
  localparam logic [7:0]  ADDR_W = {ITT_SLAVE_ADDR, 1'b0};
  localparam itt_nv_t     NV0    = '{cfg: 8'h01, high: 16'h3200, low: 16'h1400};

  logic        clk_sys    = 1'b0;
  logic        rstn       = 1'b0;
  logic [8:0]  temp_sense = 9'h000;
  itt_nv_t     nv_restore = NV0;
  wire         scl;
  wire         sda_pull;
  logic        sda_o;
  logic        sda_oe;
  itt_nv_t     nv_image;
  logic        nv_write;
  logic [15:0] temp_word;
  logic        conv_busy;
  logic        conv_done;
  logic        thermal_alarm_output;
  int          n_errors    = 0;
  int          check_count = 0;
  int          n_writes    = 0;
  // Open-drain line with pull-up
  wire         sda = ~(sda_oe | sda_pull);

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (nv_write === 1'b1) n_writes <= n_writes + 1;

  itt_thermostat #(.CONV_CYCLES(CONV), .SLAVE_ADDR(ITT_SLAVE_ADDR)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .temp_sense(temp_sense), .nv_restore(nv_restore),
    .nv_image(nv_image), .nv_write(nv_write), .temp_word(temp_word),
    .conv_busy(conv_busy), .conv_done(conv_done),
    .thermal_alarm_output(thermal_alarm_output));

  itt_master_model master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Start, write address, command and n data bytes most significant first
  task automatic send(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic ack_n;
    master.start();
    master.wbyte(ADDR_W, ack_n);
    check(ack_n, 1'b0, "address ack");
    master.wbyte(cmd, ack_n);
    check(ack_n, 1'b0, "command ack");
    for (int i = n; i > 0; i--) begin
      master.wbyte(d[8*i-1 -: 8], ack_n);
      check(ack_n, 1'b0, "data ack");
    end
  endtask

  task automatic t_bad_addr();
    logic ack_n;
    master.start();
    master.wbyte(ADDR_W ^ 8'h02, ack_n);
    check(ack_n, 1'b1, "foreign address answered");
    master.stop();
    check(nv_image, NV0, "settings after foreign address");
  endtask

  task automatic t_setup();
    int base;
    base = n_writes;
    send(ITT_CMD_CFG, 1, 16'h0002);
    check(nv_image.cfg, 8'h02, "config");
    check(thermal_alarm_output, 1'b0, "idle alarm active high");
    send(ITT_CMD_HIGH, 2, 16'h2800);
    check(nv_image.high, 16'h2800, "high limit");
    send(ITT_CMD_HIGH, 1, 16'h0077);
    send(ITT_CMD_LOW, 2, 16'h0A00);
    check(nv_image.high, 16'h2800, "high after lone byte");
    check(nv_image.low, 16'h0A00, "low limit");
    check(nv_image.cfg, 8'h02, "config kept over restarts");
    check(n_writes - base, 3, "settings write pulses");
    send(ITT_CMD_CONV, 0, 16'h0000);
    master.stop();
    check(conv_busy, 1'b1, "conversion running");
  endtask

  // Limits are 80 and 20 half degrees; each case waits for the next result
  task automatic t_conv();
    logic [8:0] tin [7] = '{9'd81, 9'd50, 9'd20, 9'd19, 9'd80, 9'h100, 9'h0FF};
    logic [8:0] tex [7] = '{9'd81, 9'd50, 9'd20, 9'd19, 9'd80, 9'h192, 9'h0FA};
    logic       alm [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    int         k;
    for (int i = 0; i < 7; i++) begin
      temp_sense = tin[i];
      for (k = 0; k < 4 * CONV; k++) begin
        step(1);
        if (conv_done === 1'b1) break;
      end
      check(k < 4 * CONV, 1'b1, "repeated result");
      check(temp_word, {tex[i], 7'h00}, "result word");
      step(1);
      check(thermal_alarm_output, alm[i], "alarm");
    end
  endtask

  task automatic t_polarity();
    send(ITT_CMD_CFG, 1, 16'h0000);
    master.stop();
    step(4);
    check(thermal_alarm_output, 1'b0, "alarm active low");
    send(ITT_CMD_CFG, 1, 16'h00FF);
    master.stop();
    step(4);
    check(nv_image.cfg, 8'h03, "config spare bits");
    check(thermal_alarm_output, 1'b1, "alarm active high again");
    for (int j = 0; j < 2 * CONV && conv_busy === 1'b1; j++) step(1);
    check(conv_busy, 1'b0, "one-shot conversion stops");
  endtask

  task automatic t_read();
    logic       ack_n;
    logic [7:0] b1;
    logic [7:0] b2;
    master.start();
    master.wbyte({ITT_SLAVE_ADDR, 1'b1}, ack_n);
    check(ack_n, 1'b0, "read address ack");
    master.rbyte(1'b0, b1);
    master.rbyte(1'b1, b2);
    master.stop();
    check({b1, b2}, {9'h0FA, 7'h00}, "read result");
    check(sda_o, 1'b0, "open-drain output value");
  endtask

  initial begin
    #60000;
    n_errors++;
    give_verdict();
  end

  initial begin
    step(16);
    check(thermal_alarm_output, 1'b0 ^ ITT_ALARM_RST, "alarm in reset");
    rstn = 1'b1;
    step(12);
    check(nv_image, NV0, "restored settings");
    check(thermal_alarm_output, 1'b1, "restored alarm inactive");
    t_bad_addr();
    t_setup();
    t_conv();
    t_polarity();
    t_read();
    give_verdict();
  end
endmodule
